// ### hw/lvdc_top.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module lvdc_top
   import lvdc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [DATA_W-1:0] rdata,
   // Analog side status (asynchronous)
   input wire logic comp_below_async,
   input wire logic ref_ready_async,
   // Core power state
   input wire logic sleep_mode,
   // Analog side control
   output logic detector_power_enable,
   output logic [CTRL_LEVEL_W-1:0] divider_tap_sel,
   output logic external_detect_input_sel,
   // Flags, interrupt and wake
   output logic low_supply_flag,
   output logic irq,
   output logic wake_req,
   output logic wake_to_vector
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // A level code is usable for detection unless it is the reserved code
   function automatic logic level_valid(input logic [CTRL_LEVEL_W-1:0] level);
      level_valid = (level != LEVEL_RESERVED);
   endfunction

   function automatic logic level_external(input logic [CTRL_LEVEL_W-1:0] level);
      level_external = (level == LEVEL_EXTERNAL);
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [CTRL_LEVEL_W-1:0] level_reg;
   logic enable_reg;
   logic stable_reg;
   logic [1:0] ien_reg;
   logic [IRQ_W-1:0] istat_reg;
   logic [IRQ_W-1:0] istat_next;
   logic [IRQ_W-1:0] imask_reg;
   logic [SYNC_W-1:0] sync_levels;
   logic comp_below_sync;
   logic ref_ready_sync;
   logic detect_now;
   logic stable_rise;
   logic flag_next;
   logic [DATA_W-1:0] rdata_next;
   logic wr_ctrl;
   logic wr_flag;
   logic rd_istat;

   assign wr_ctrl = wr_en && (addr == OFS_CONTROL);
   assign wr_flag = wr_en && (addr == OFS_FLAG);
   assign rd_istat = rd_en && (addr == OFS_IRQ_STATUS);

   // ****************************************************************
   // Synchronisation of the analog side
   // ****************************************************************

   // Raw comparator output may chatter; only the synchronised copy is used
   lvdc_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({ref_ready_async, comp_below_async}),
      .sync_out(sync_levels)
   );

   assign comp_below_sync = sync_levels[0];
   assign ref_ready_sync = sync_levels[1];

   // ****************************************************************
   // Control register
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         level_reg <= CTRL_RESET[CTRL_LEVEL_LSB +: CTRL_LEVEL_W];
         enable_reg <= CTRL_RESET[CTRL_ENABLE_BIT];
      end
      else if (wr_ctrl)
      begin
         // Bits 7-6 and the stable bit are not stored
         level_reg <= wdata[CTRL_LEVEL_LSB +: CTRL_LEVEL_W];
         enable_reg <= wdata[CTRL_ENABLE_BIT];
      end
   end

   // ****************************************************************
   // Reference stable flag
   // ****************************************************************

   // Follows the analog ready level, so settling time is clock independent
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stable_reg <= 1'b0;
      end
      else
      begin
         stable_reg <= enable_reg && ref_ready_sync;
      end
   end

   assign stable_rise = enable_reg && ref_ready_sync && !stable_reg;

   // ****************************************************************
   // Detection and low supply flag
   // ****************************************************************

   // Gating on stable keeps settling glitches out of the flag
   assign detect_now = enable_reg && stable_reg && level_valid(level_reg)
                       && comp_below_sync;

   // Detection runs regardless of sleep_mode
   always_comb
   begin
      flag_next = low_supply_flag;
      if (wr_flag && wdata[FLAG_LOW_SUPPLY_BIT])
      begin
         flag_next = 1'b0;
      end
      if (detect_now)
      begin
         // Set beats clear: a persisting low supply keeps the flag up
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low_supply_flag <= 1'b0;
      end
      else
      begin
         low_supply_flag <= flag_next;
      end
   end

   // ****************************************************************
   // Interrupt enables, status and mask
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ien_reg <= IEN_RESET;
      end
      else if (wr_en && (addr == OFS_IRQ_ENABLE))
      begin
         ien_reg[IEN_LOW_SUPPLY_BIT] <= wdata[IEN_LOW_SUPPLY_BIT];
         ien_reg[IEN_GLOBAL_BIT] <= wdata[IEN_GLOBAL_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         imask_reg <= IRQ_RESET;
      end
      else if (wr_en && (addr == OFS_IRQ_MASK))
      begin
         imask_reg <= wdata[IRQ_W-1:0];
      end
   end

   // Read clears; a new event in the same cycle survives
   always_comb
   begin
      istat_next = rd_istat ? IRQ_RESET : istat_reg;
      if (detect_now && !low_supply_flag)
      begin
         istat_next[IRQ_DETECT_BIT] = 1'b1;
      end
      if (stable_rise)
      begin
         istat_next[IRQ_STABLE_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         istat_reg <= IRQ_RESET;
      end
      else
      begin
         istat_reg <= istat_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(istat_next & imask_reg);
      end
   end

   // ****************************************************************
   // Wake from sleep
   // ****************************************************************

   // Wake needs the source enable; the vector also needs the global enable
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_req <= 1'b0;
         wake_to_vector <= 1'b0;
      end
      else
      begin
         wake_req <= sleep_mode && flag_next && ien_reg[IEN_LOW_SUPPLY_BIT];
         wake_to_vector <= flag_next && ien_reg[IEN_LOW_SUPPLY_BIT]
                           && ien_reg[IEN_GLOBAL_BIT];
      end
   end

   // ****************************************************************
   // Analog side control outputs
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         detector_power_enable <= 1'b0;
         divider_tap_sel <= TAP_NONE;
         external_detect_input_sel <= 1'b0;
      end
      else
      begin
         detector_power_enable <= enable_reg;
         // Reserved and external codes select no internal tap
         if (level_external(level_reg) || !level_valid(level_reg))
         begin
            divider_tap_sel <= TAP_NONE;
         end
         else
         begin
            divider_tap_sel <= level_reg;
         end
         external_detect_input_sel <= level_external(level_reg);
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   always_comb
   begin
      rdata_next = '0;
      case (addr)
         OFS_CONTROL:
         begin
            rdata_next[CTRL_LEVEL_LSB +: CTRL_LEVEL_W] = level_reg;
            rdata_next[CTRL_ENABLE_BIT] = enable_reg;
            rdata_next[CTRL_STABLE_BIT] = stable_reg;
         end
         OFS_FLAG:
         begin
            rdata_next[FLAG_LOW_SUPPLY_BIT] = low_supply_flag;
         end
         OFS_IRQ_ENABLE:
         begin
            rdata_next[IEN_GLOBAL_BIT:IEN_LOW_SUPPLY_BIT] = ien_reg;
         end
         OFS_IRQ_STATUS:
         begin
            rdata_next[IRQ_W-1:0] = istat_reg;
         end
         OFS_IRQ_MASK:
         begin
            rdata_next[IRQ_W-1:0] = imask_reg;
         end
         default:
         begin
            rdata_next = '0;
         end
      endcase
   end

   // Data appear only in the cycle after the read strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata <= '0;
      end
      else if (rd_en)
      begin
         rdata <= rdata_next;
      end
      else
      begin
         rdata <= '0;
      end
   end

endmodule

// ### hw/lvdc_pkg.sv
package lvdc_pkg;

   // ****************************************************************
   // Register map (byte offsets on the plain register port)
   // ****************************************************************
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_FLAG = 4'h1;
   localparam logic [3:0] OFS_IRQ_ENABLE = 4'h2;
   localparam logic [3:0] OFS_IRQ_STATUS = 4'h3;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h4;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int unsigned CTRL_LEVEL_LSB = 0;
   localparam int unsigned CTRL_LEVEL_W = 4;
   localparam int unsigned CTRL_ENABLE_BIT = 4;
   localparam int unsigned CTRL_STABLE_BIT = 5;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'h1F;
   localparam logic [7:0] CTRL_RESET = 8'h05;

   localparam logic [3:0] LEVEL_RESERVED = 4'h0;
   localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;
   localparam logic [3:0] TAP_NONE = 4'h0;

   // ****************************************************************
   // Flag, enable and interrupt register fields
   // ****************************************************************
   localparam int unsigned FLAG_LOW_SUPPLY_BIT = 0;
   localparam int unsigned IEN_LOW_SUPPLY_BIT = 0;
   localparam int unsigned IEN_GLOBAL_BIT = 1;
   localparam logic [1:0] IEN_RESET = 2'h0;

   localparam int unsigned IRQ_W = 2;
   localparam int unsigned IRQ_DETECT_BIT = 0;
   localparam int unsigned IRQ_STABLE_BIT = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;

   localparam int unsigned SYNC_W = 2;

endpackage

// ### hw/lvdc_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser for asynchronous analog-side levels
module lvdc_sync #(
   parameter int unsigned WIDTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ****************************************************************
   // First stage feeds only the second stage
   // ****************************************************************
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// ### tb/lvdc_top_chk.sv
`timescale 1ns/1ps

// ****************************************************************
// Port checker
// ****************************************************************
module lvdc_chk
   import lvdc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [DATA_W-1:0] rdata,
   // Analog side and power state
   input wire logic comp_below_async,
   input wire logic ref_ready_async,
   input wire logic sleep_mode,
   // Outputs
   input wire logic detector_power_enable,
   input wire logic [CTRL_LEVEL_W-1:0] divider_tap_sel,
   input wire logic external_detect_input_sel,
   input wire logic low_supply_flag,
   input wire logic wake_req,
   input wire logic wake_to_vector
);
   logic [2:0] rdy_low_cnt;
   logic [3:0] wr_lvl;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Saturating count of edges with the reference not ready
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         rdy_low_cnt <= 3'h0;
      else if (ref_ready_async)
         rdy_low_cnt <= 3'h0;
      else if (rdy_low_cnt != 3'h7)
         rdy_low_cnt <= rdy_low_cnt + 3'h1;

   always_ff @(posedge clk)
      if (wr_en && addr == OFS_CONTROL)
         wr_lvl <= wdata[3:0];

   chk_top_bits_zero: assert property (
      rd_en && addr == OFS_CONTROL |=> rdata[7:6] == 2'b00) else $error("control top bits set");
   chk_power_follow: assert property (
      wr_en && addr == OFS_CONTROL |=> ##1 detector_power_enable == $past(wdata[4], 2))
      else $error("power enable does not follow write");
   chk_tap_map: assert property (
      wr_en && addr == OFS_CONTROL |=> ##1 (divider_tap_sel == ((wr_lvl == 4'hF) ? 4'h0 : wr_lvl)
      && external_detect_input_sel == (wr_lvl == 4'hF))) else $error("tap select wrong");
   chk_stable_wait: assert property (
      rd_en && addr == OFS_CONTROL && rdy_low_cnt >= 3'h5 |=> !rdata[CTRL_STABLE_BIT])
      else $error("stable flag without ready reference");
   chk_detect_cause: assert property (
      $rose(low_supply_flag) |-> $past(comp_below_async, 3) && $past(ref_ready_async, 4))
      else $error("flag set without synchronised cause");
   chk_sleep_wake: assert property (
      wake_req |-> $past(sleep_mode) && low_supply_flag) else $error("wake without sleep and flag");
   chk_vector_gate: assert property (
      wake_to_vector |-> low_supply_flag) else $error("vector request without flag");
   chk_reset_off: assert property (
      $rose(rst_n) |-> !detector_power_enable) else $error("detector on after reset");
endmodule

bind lvdc_top lvdc_chk lvdc_chk_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
   .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .comp_below_async(comp_below_async),
   .ref_ready_async(ref_ready_async), .sleep_mode(sleep_mode),
   .detector_power_enable(detector_power_enable), .divider_tap_sel(divider_tap_sel),
   .external_detect_input_sel(external_detect_input_sel), .low_supply_flag(low_supply_flag),
   .wake_req(wake_req), .wake_to_vector(wake_to_vector));

// ### tb/tb_lvdc_top.sv
`timescale 1ns/1ps

// ****************************************************************
// Bench
// ****************************************************************
module tb_lvdc_top
   import lvdc_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, sleep_mode = 1'b0;
   logic comp_below_async = 1'b0, ref_ready_async = 1'b0;
   logic [ADDR_W-1:0] addr = 4'h0;
   logic [DATA_W-1:0] wdata = 8'h00, rdata, rd_val;
   logic [3:0] divider_tap_sel;
   logic detector_power_enable, external_detect_input_sel, low_supply_flag;
   logic irq, wake_req, wake_to_vector;
   int fail_count = 0, samples_checked = 0;

   always #2 clk = ~clk;

   lvdc_top lvdc_top_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .comp_below_async(comp_below_async),
      .ref_ready_async(ref_ready_async), .sleep_mode(sleep_mode),
      .detector_power_enable(detector_power_enable), .divider_tap_sel(divider_tap_sel),
      .external_detect_input_sel(external_detect_input_sel),
      .low_supply_flag(low_supply_flag), .irq(irq), .wake_req(wake_req),
      .wake_to_vector(wake_to_vector));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      if (fail_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so take them 1 ns past that edge
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic t_levels;
      wr(OFS_CONTROL, 8'hFF);
      rd(OFS_CONTROL, rd_val);
      chk(rd_val, 8'h1F);
      for (int i = 0; i < 16; i++)
      begin
         wr(OFS_CONTROL, {4'h1, 4'(i)});
         cyc(2);
         chk({4'h0, divider_tap_sel}, (i == 0 || i == 15) ? 8'h00 : 8'(i));
         chk({6'h00, external_detect_input_sel, detector_power_enable},
             {6'h00, i == 15, 1'b1});
      end
      wr(OFS_CONTROL, 8'h05);
      cyc(2);
      chk({7'h00, detector_power_enable}, 8'h00);
   endtask

   // Setup in the documented order, with a low supply already present while settling
   task automatic t_setup;
      wr(OFS_IRQ_MASK, 8'h01);
      wr(OFS_CONTROL, 8'h03);
      wr(OFS_IRQ_ENABLE, 8'h00);
      comp_below_async <= 1'b1;
      wr(OFS_CONTROL, 8'h13);
      cyc(8);
      chk({7'h00, low_supply_flag}, 8'h00);
      rd(OFS_CONTROL, rd_val);
      chk(rd_val, 8'h13);
      @(posedge clk);
      ref_ready_async <= 1'b1;
      for (int n = 0; n < 20 && !rd_val[5]; n++)
         rd(OFS_CONTROL, rd_val);
      chk(rd_val, 8'h33);
      cyc(4);
      chk({6'h00, irq, low_supply_flag}, 8'h03);
      wr(OFS_FLAG, 8'h01);
      cyc(2);
      chk({7'h00, low_supply_flag}, 8'h01);
      @(posedge clk);
      comp_below_async <= 1'b0;
      cyc(4);
      wr(OFS_FLAG, 8'h01);
      rd(OFS_FLAG, rd_val);
      chk(rd_val, 8'h00);
      rd(OFS_IRQ_STATUS, rd_val);
      chk(rd_val, 8'h03);
      rd(OFS_IRQ_STATUS, rd_val);
      chk({rd_val[6:0], irq}, 8'h00);
   endtask

   task automatic t_sleep;
      wr(OFS_IRQ_ENABLE, 8'h01);
      sleep_mode <= 1'b1;
      comp_below_async <= 1'b1;
      cyc(5);
      chk({5'h00, low_supply_flag, wake_req, wake_to_vector}, 8'h06);
      wr(OFS_IRQ_ENABLE, 8'h03);
      cyc(2);
      chk({7'h00, wake_to_vector}, 8'h01);
      @(posedge clk);
      sleep_mode <= 1'b0;
      comp_below_async <= 1'b0;
      cyc(4);
      wr(OFS_FLAG, 8'h01);
      cyc(2);
      chk({6'h00, wake_req, wake_to_vector}, 8'h00);
      wr(OFS_IRQ_ENABLE, 8'h00);
   endtask

   task automatic t_codes;
      wr(OFS_CONTROL, 8'h1F);
      comp_below_async <= 1'b1;
      cyc(5);
      chk({7'h00, low_supply_flag}, 8'h01);
      wr(OFS_CONTROL, 8'h10);
      wr(OFS_FLAG, 8'h01);
      cyc(5);
      chk({7'h00, low_supply_flag}, 8'h00);
      // Valid level but power off: a persisting low supply must not set the flag
      wr(OFS_CONTROL, 8'h03);
      cyc(5);
      chk({6'h00, detector_power_enable, low_supply_flag}, 8'h00);
      rd(OFS_CONTROL, rd_val);
      chk(rd_val, 8'h03);
      @(posedge clk);
      comp_below_async <= 1'b0;
   endtask

   task automatic t_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      cyc(2);
      chk({7'h00, detector_power_enable}, 8'h00);
      @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_CONTROL, rd_val);
      chk(rd_val, CTRL_RESET);
      rd(4'h9, rd_val);
      chk(rd_val, 8'h00);
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_CONTROL, rd_val);
      chk(rd_val, CTRL_RESET);
      t_levels;
      t_setup;
      t_sleep;
      t_codes;
      t_reset;
      end_of_test;
   end

   // Whole run is under two hundred cycles, so this span only trips on a hang
   initial
   begin
      #40000;
      fail_count++;
      end_of_test;
   end
endmodule
